// >>> sbm_pkg.sv
// Purpose: shared constants and types for the serial bus mode and status block
// Assumes: 20 MHz system clock, byte-wide register port
// Notes:   register offsets, field positions, register reset values and the half-bit timing count live here
//
// What this block does
// - A two-bit mode field picks port mode with outputs off (00), clocked serial (01), bus mode (10), 11 reserved.
// - The transfer flag reads 1 while a transfer runs and 0 once it has ended.
// - The shift flag reads 1 while bits are shifting and 0 once shifting has ended.
// - A control bit stops or keeps the interface in the second idle mode; clocked serial mode never runs there.
package sbm_pkg;

   // ***************************************************************
   // register map
   // ***************************************************************
   localparam logic [15:0] ADDR_CTRL2    = 16'h1241;
   localparam logic [15:0] ADDR_DATA     = 16'h1242;
   localparam logic [15:0] ADDR_STATUS   = 16'h1243;
   localparam logic [15:0] ADDR_IDLE     = 16'h1244;
   localparam logic [15:0] ADDR_IRQ_STAT = 16'h1246;
   localparam logic [15:0] ADDR_IRQ_MASK = 16'h1247;

   // ***************************************************************
   // field positions and reset values
   // ***************************************************************
   localparam int MODE_LSB     = 2;
   localparam int STAT_XFER    = 1;
   localparam int STAT_SHIFT   = 0;
   localparam int IDLE_OP_BIT  = 0;
   localparam int IRQ_DONE     = 0;
   localparam int IRQ_OVERRUN  = 1;
   localparam logic [7:0] CTRL2_RST = 8'h00;
   localparam logic [7:0] IDLE_RST  = 8'h00;
   localparam logic [7:0] IRQ_RST   = 8'h00;
   localparam logic [7:0] DATA_RST  = 8'h00;
   localparam logic [1:0] IRQ_USED  = 2'h3;

   // ***************************************************************
   // modes and timing
   // ***************************************************************
   typedef enum logic [1:0] {
      SBM_MODE_PORT = 2'h0,
      SBM_MODE_SYNC = 2'h1,
      SBM_MODE_I2C  = 2'h2,
      SBM_MODE_RSVD = 2'h3
   } sbm_mode_e;

   typedef enum logic [1:0] {
      SBM_ST_IDLE  = 2'h0,
      SBM_ST_SHIFT = 2'h1,
      SBM_ST_TAIL  = 2'h3
   } sbm_state_e;

   localparam int CLK_MHZ       = 20;
   localparam int HALF_BIT_NS   = 500;
   localparam int HALF_BIT_CYC  = (HALF_BIT_NS * CLK_MHZ) / 1000;
   localparam int BITS_PER_BYTE = 8;

   // pin drive bundle of the serial engine
   typedef struct packed {
      logic sck;
      logic sck_oe;
      logic sdo;
      logic sdo_oe;
   } sbm_pins_s;

endpackage

// >>> sbm_shifter.sv
// Purpose: eight-bit shift engine with clock generation
// Assumes: run low holds every flop; sdi synchronous to clk
// Notes:   open-drain drive in bus mode, push-pull in clocked serial mode
`timescale 1ns/1ps
module sbm_shifter #(
   parameter int HALF_CYC = sbm_pkg::HALF_BIT_CYC
) (
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              run,
   input  wire logic              start,
   input  wire logic              out_en,
   input  wire logic              i2c,
   input  wire logic [7:0]        tx,
   input  wire logic              sdi,
   output logic                   busy,
   output logic                   shifting,
   output logic                   done,
   output logic [7:0]             rx,
   output sbm_pkg::sbm_pins_s     pins
);

   // ***************************************************************
   // sequencing
   // ***************************************************************
   localparam logic [15:0] HALF_LAST = 16'(HALF_CYC - 1);
   sbm_pkg::sbm_state_e st_r;
   logic [15:0]         div_r;
   logic [2:0]          bit_r;
   logic [7:0]          sh_r;
   logic                hi_r;
   logic                in_r;
   logic                tick;

   assign tick = (div_r == HALF_LAST);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_r  <= sbm_pkg::SBM_ST_IDLE;
         div_r <= 16'h0000;
         bit_r <= 3'h0;
         sh_r  <= 8'h00;
         hi_r  <= 1'b1;
         in_r  <= 1'b0;
         rx    <= 8'h00;
         done  <= 1'b0;
      end else if (run) begin
         done <= 1'b0;
         case (st_r)
            sbm_pkg::SBM_ST_IDLE: begin
               div_r <= 16'h0000;
               hi_r  <= 1'b1;
               if (start) begin
                  sh_r  <= tx;
                  bit_r <= 3'h0;
                  hi_r  <= 1'b0;
                  st_r  <= sbm_pkg::SBM_ST_SHIFT;
               end
            end
            sbm_pkg::SBM_ST_SHIFT: begin
               div_r <= tick ? 16'h0000 : div_r + 16'h0001;
               if (tick) begin
                  if (!hi_r) begin
                     // rising half: capture input while output holds
                     hi_r <= 1'b1;
                     in_r <= sdi;
                  end else begin
                     // falling half: output moves, capture enters the register
                     sh_r <= {sh_r[6:0], in_r};
                     if (bit_r == 3'h7) begin
                        // clock stays high into the tail, no extra edge
                        st_r <= sbm_pkg::SBM_ST_TAIL;
                     end else begin
                        hi_r  <= 1'b0;
                        bit_r <= bit_r + 3'h1;
                     end
                  end
               end
            end
            sbm_pkg::SBM_ST_TAIL: begin
               hi_r  <= 1'b1;
               div_r <= tick ? 16'h0000 : div_r + 16'h0001;
               if (tick) begin
                  rx   <= sh_r;
                  done <= 1'b1;
                  st_r <= sbm_pkg::SBM_ST_IDLE;
               end
            end
            default: st_r <= sbm_pkg::SBM_ST_IDLE;
         endcase
      end
   end

   // ***************************************************************
   // registered flags and pin drive
   // ***************************************************************
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         busy     <= 1'b0;
         shifting <= 1'b0;
      end else if (run) begin
         busy     <= (st_r != sbm_pkg::SBM_ST_IDLE) || start;
         shifting <= (st_r == sbm_pkg::SBM_ST_SHIFT) && !(tick && hi_r && bit_r == 3'h7)
                     || (st_r == sbm_pkg::SBM_ST_IDLE && start);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pins <= '{sck: 1'b1, sck_oe: 1'b0, sdo: 1'b1, sdo_oe: 1'b0};
      end else if (run) begin
         pins.sck    <= hi_r;
         pins.sdo    <= (st_r == sbm_pkg::SBM_ST_SHIFT) ? sh_r[7] : 1'b1;
         pins.sck_oe <= out_en && (i2c ? !hi_r : 1'b1);
         pins.sdo_oe <= out_en && (i2c ? (st_r == sbm_pkg::SBM_ST_SHIFT) && !sh_r[7] : 1'b1);
      end
   end

endmodule // sbm_shifter

// >>> sbm_top.sv
// Purpose: mode selection, status flags and registers of one serial bus channel
// Assumes: register strobes one cycle wide, never both at once
// Notes:   read data valid in the cycle after the read strobe
`timescale 1ns/1ps
module sbm_top #(
   parameter int HALF_CYC = sbm_pkg::HALF_BIT_CYC
) (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        ce,
   input  wire logic [15:0] addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [7:0]       rdata,
   output logic             irq,
   input  wire logic        second_low_power_idle,
   input  wire logic        sdi,
   output logic             sck_o,
   output logic             sck_oe,
   output logic             sdo_o,
   output logic             sdo_oe
);

   // ***************************************************************
   // registers
   // ***************************************************************
   logic [7:0] ctrl2_r;
   logic [7:0] idle_r;
   logic [1:0] irq_stat_r;
   logic [1:0] irq_mask_r;
   logic [1:0] irq_stat_nxt;
   sbm_pkg::sbm_mode_e mode;
   logic       wr_ctrl2;
   logic       wr_idle;
   logic       wr_data;
   logic       wr_istat;
   logic       wr_imask;

   assign wr_ctrl2 = wr && addr == sbm_pkg::ADDR_CTRL2;
   assign wr_idle  = wr && addr == sbm_pkg::ADDR_IDLE;
   assign wr_data  = wr && addr == sbm_pkg::ADDR_DATA;
   assign wr_istat = wr && addr == sbm_pkg::ADDR_IRQ_STAT;
   assign wr_imask = wr && addr == sbm_pkg::ADDR_IRQ_MASK;
   assign mode     = sbm_pkg::sbm_mode_e'(ctrl2_r[sbm_pkg::MODE_LSB +: 2]);

   // low two bits are kept at zero whatever software writes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl2_r <= sbm_pkg::CTRL2_RST;
      end else if (ce && wr_ctrl2) begin
         ctrl2_r <= {wdata[7:2], 2'h0};
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         idle_r <= sbm_pkg::IDLE_RST;
      end else if (ce && wr_idle) begin
         idle_r <= {7'h00, wdata[sbm_pkg::IDLE_OP_BIT]};
      end
   end

   // ***************************************************************
   // run gating in the second idle mode
   // ***************************************************************
   logic run;
   logic active_mode;
   assign active_mode = (mode == sbm_pkg::SBM_MODE_SYNC) || (mode == sbm_pkg::SBM_MODE_I2C);
   assign run = ce && !(second_low_power_idle &&
                (!idle_r[sbm_pkg::IDLE_OP_BIT] || mode == sbm_pkg::SBM_MODE_SYNC));

   // ***************************************************************
   // shift engine
   // ***************************************************************
   logic               busy;
   logic               shifting;
   logic               done;
   logic [7:0]         rx;
   logic               start;
   sbm_pkg::sbm_pins_s pins;

   assign start = run && wr_data && active_mode && !busy;

   sbm_shifter #(
      .HALF_CYC (HALF_CYC)
   ) u_shift (
      .clk      (clk),
      .rstn     (rstn),
      .run      (run),
      .start    (start),
      .out_en   (active_mode),
      .i2c      (mode == sbm_pkg::SBM_MODE_I2C),
      .tx       (wdata),
      .sdi      (sdi),
      .busy     (busy),
      .shifting (shifting),
      .done     (done),
      .rx       (rx),
      .pins     (pins)
   );

   // pins: port mode and reserved mode force every enable low
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sck_o  <= 1'b1;
         sck_oe <= 1'b0;
         sdo_o  <= 1'b1;
         sdo_oe <= 1'b0;
      end else if (ce) begin
         sck_o  <= pins.sck;
         sdo_o  <= pins.sdo;
         sck_oe <= pins.sck_oe && active_mode;
         sdo_oe <= pins.sdo_oe && active_mode;
      end
   end

   // ***************************************************************
   // interrupts
   // ***************************************************************
   logic [1:0] ev;
   assign ev[sbm_pkg::IRQ_DONE]    = done && run;
   assign ev[sbm_pkg::IRQ_OVERRUN] = ce && wr_data && active_mode && busy;

   always_comb begin
      irq_stat_nxt = irq_stat_r;
      if (wr_istat) begin
         irq_stat_nxt = irq_stat_nxt & ~wdata[1:0];
      end
      irq_stat_nxt = irq_stat_nxt | ev;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_stat_r <= sbm_pkg::IRQ_RST[1:0];
      end else if (ce) begin
         irq_stat_r <= irq_stat_nxt;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_mask_r <= sbm_pkg::IRQ_RST[1:0];
      end else if (ce && wr_imask) begin
         irq_mask_r <= wdata[1:0] & sbm_pkg::IRQ_USED;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(irq_stat_nxt & irq_mask_r);
      end
   end

   // ***************************************************************
   // read port
   // ***************************************************************
   logic [7:0] status;
   always_comb begin
      status = 8'h00;
      status[sbm_pkg::STAT_XFER]  = busy;
      status[sbm_pkg::STAT_SHIFT] = shifting;
   end

   // status has no write path, so writes to it fall through
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else if (ce) begin
         rdata <= 8'h00;
         if (rd) begin
            case (addr)
               sbm_pkg::ADDR_CTRL2:    rdata <= ctrl2_r;
               sbm_pkg::ADDR_DATA:     rdata <= rx;
               sbm_pkg::ADDR_STATUS:   rdata <= status;
               sbm_pkg::ADDR_IDLE:     rdata <= idle_r;
               sbm_pkg::ADDR_IRQ_STAT: rdata <= {6'h00, irq_stat_r};
               sbm_pkg::ADDR_IRQ_MASK: rdata <= {6'h00, irq_mask_r};
               default:                rdata <= 8'h00;
            endcase
         end
      end
   end

endmodule // sbm_top

// >>> sbm_top_props.sv
// Purpose: concurrent checks on the ports of sbm_top
// Assumes: ce held high by the bench
// Notes:   pins lag the engine, so mode and idle are tracked four cycles deep
`timescale 1ns/1ps
module sbm_top_props #(
   parameter int HALF_CYC = sbm_pkg::HALF_BIT_CYC
) (
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        ce,
   input wire logic [15:0] addr,
   input wire logic [7:0]  wdata,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [7:0]  rdata,
   input wire logic        irq,
   input wire logic        second_low_power_idle,
   input wire logic        sdi,
   input wire logic        sck_o,
   input wire logic        sck_oe,
   input wire logic        sdo_o,
   input wire logic        sdo_oe
);
   // **********
   // mode tracking
   // **********
   logic [1:0] mode_r;
   logic       op_r;
   logic [3:0] off_r, bus_r, syn_r, frz_r;
   logic       st_rd;
   assign st_rd = ce && rd && addr == sbm_pkg::ADDR_STATUS;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_r <= 2'h0;
         op_r   <= 1'h0;
      end else if (ce && wr && addr == sbm_pkg::ADDR_CTRL2) begin
         mode_r <= wdata[sbm_pkg::MODE_LSB +: 2];
      end else if (ce && wr && addr == sbm_pkg::ADDR_IDLE) begin
         op_r <= wdata[sbm_pkg::IDLE_OP_BIT];
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         off_r <= 4'h0;
         bus_r <= 4'h0;
         syn_r <= 4'h0;
         frz_r <= 4'h0;
      end else begin
         off_r <= {off_r[2:0], mode_r[0] == mode_r[1]};
         bus_r <= {bus_r[2:0], mode_r == 2'h2};
         syn_r <= {syn_r[2:0], mode_r == 2'h1};
         frz_r <= {frz_r[2:0], second_low_power_idle && (mode_r == 2'h1 || !op_r)};
      end
   end
   // **********
   // properties
   // **********
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   property p_out_off;
      &off_r |-> !sck_oe && !sdo_oe;
   endproperty
   a_out_off: assert property (p_out_off) else $error("pins driven with outputs off");
   property p_bus_od;
      &bus_r |-> !(sdo_oe && sdo_o) && !(sck_oe && sck_o);
   endproperty
   a_bus_od: assert property (p_bus_od) else $error("bus mode pin driven high");
   property p_stat_form;
      st_rd |=> rdata[7:2] == 6'h00 && (rdata[sbm_pkg::STAT_XFER] || !rdata[sbm_pkg::STAT_SHIFT]);
   endproperty
   a_stat_form: assert property (p_stat_form) else $error("shift flag without transfer flag");
   property p_stat_off;
      &off_r && st_rd |=> rdata == 8'h00;
   endproperty
   a_stat_off: assert property (p_stat_off) else $error("transfer seen with outputs off");
   property p_hold;
      &frz_r |-> $stable(sck_o) && $stable(sdo_o);
   endproperty
   a_hold: assert property (p_hold) else $error("pins moved in idle");
   c_sync: cover property (&syn_r && sck_oe);
   c_bus: cover property (&bus_r && sdo_oe);
   c_hold: cover property (&syn_r && &frz_r);
   c_irq: cover property ($rose(irq));
endmodule // sbm_top_props
bind sbm_top sbm_top_props #(.HALF_CYC(HALF_CYC)) sbm_top_props_inst (
   .clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata(rdata), .irq(irq), .second_low_power_idle(second_low_power_idle), .sdi(sdi), .sck_o(sck_o),
   .sck_oe(sck_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe)
);

// >>> sbm_far_dev.sv
// Purpose: serial device model on the far side of the pins
// Assumes: sck idles high, bits MSB first, change on fall
// Notes:   sdi inverts outside frames
`timescale 1ns/1ps
module sbm_far_dev (
   input  wire logic       sck,
   input  wire logic       sdo,
   input  wire logic       load,
   input  wire logic [7:0] tx,
   output logic            sdi,
   output logic [7:0]      rx
);
   logic [7:0] sh_r;
   logic [3:0] cnt_r;
   initial begin
      sdi   = 1'h0;
      rx    = 8'h00;
      sh_r  = 8'h00;
      cnt_r = 4'h8;
   end
   always @(posedge load) begin
      sh_r  <= tx;
      cnt_r <= 4'h0;
      sdi   <= ~sdi;
   end
   always @(negedge sck) begin
      if (cnt_r < 4'h8) begin
         sdi   <= sh_r[7];
         sh_r  <= {sh_r[6:0], 1'h0};
         cnt_r <= cnt_r + 4'h1;
      end else begin
         sdi <= ~sdi;
      end
   end
   always @(posedge sck) begin
      rx <= {rx[6:0], sdo};
   end
endmodule // sbm_far_dev

// >>> sbm_top_tb.sv
// Purpose: self-checking bench for sbm_top
// Assumes: HALF_CYC set small, ce tied high
// Notes:   pins pulled up when not driven
`timescale 1ns/1ps
module sbm_top_tb;
   logic        clk, rstn, ce, wr, rd, second_low_power_idle, sdi, irq, load;
   logic        sck_o, sck_oe, sdo_o, sdo_oe;
   logic [15:0] addr;
   logic [7:0]  wdata, rdata, tx, rx;
   int          mismatches, compares, cyc;
   wire         sck_w = sck_oe ? sck_o : 1'h1;
   wire         sdo_w = sdo_oe ? sdo_o : 1'h1;
   sbm_top #(.HALF_CYC(4)) sbm_top_inst (.clk(clk), .rstn(rstn), .ce(ce), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
      .second_low_power_idle(second_low_power_idle),
      .sdi(sdi), .sck_o(sck_o), .sck_oe(sck_oe), .sdo_o(sdo_o), .sdo_oe(sdo_oe));
   sbm_far_dev sbm_far_dev_inst (.sck(sck_w), .sdo(sdo_w), .load(load), .tx(tx),
      .sdi(sdi), .rx(rx));
   // **********
   // tasks
   // **********
   task automatic test_done();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      compares++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask
   task automatic rd_chk(input string n, input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      @(posedge clk);
      chk(n, e, rdata);
   endtask
   task automatic wait_irq(input int lim, output logic hit);
      hit = 1'h0;
      for (int i = 0; i < lim && !hit; i++) begin
         @(posedge clk);
         hit = irq === 1'h1;
      end
   endtask
   task automatic t_reset();
      rd_chk("ctrl", sbm_pkg::ADDR_CTRL2, sbm_pkg::CTRL2_RST);
      rd_chk("idle", sbm_pkg::ADDR_IDLE, sbm_pkg::IDLE_RST);
      rd_chk("istat", sbm_pkg::ADDR_IRQ_STAT, sbm_pkg::IRQ_RST);
      rd_chk("data", sbm_pkg::ADDR_DATA, sbm_pkg::DATA_RST);
      rd_chk("status", sbm_pkg::ADDR_STATUS, 8'h00);
      wr_reg(16'h1245, 8'hff);
      rd_chk("unmapped", 16'h1245, 8'h00);
      chk("oe", 8'h00, {6'h0, sck_oe, sdo_oe});
   endtask
   task automatic xfer(input logic [1:0] m, input logic op, input logic idl, input logic [7:0] d);
      logic go, done, hit;
      go   = m[0] ^ m[1];
      done = go && !(idl && (!op || m == 2'h1));
      wr_reg(sbm_pkg::ADDR_CTRL2, {4'h0, m, 2'h0});
      rd_chk("mode", sbm_pkg::ADDR_CTRL2, {4'h0, m, 2'h0});
      wr_reg(sbm_pkg::ADDR_IDLE, {7'h0, op});
      tx   <= ~d;
      load <= 1'h1;
      wr_reg(sbm_pkg::ADDR_DATA, d);
      load <= 1'h0;
      wr_reg(sbm_pkg::ADDR_DATA, ~d);
      wr_reg(sbm_pkg::ADDR_STATUS, 8'h00);
      rd_chk("busy", sbm_pkg::ADDR_STATUS, {6'h0, go, go});
      rd_chk("ovr", sbm_pkg::ADDR_IRQ_STAT, {6'h0, go, 1'h0});
      wr_reg(sbm_pkg::ADDR_IRQ_STAT, 8'h02);
      second_low_power_idle <= idl;
      wait_irq(200, hit);
      chk("done", {7'h0, done}, {7'h0, hit});
      if (go && !done) begin
         rd_chk("frozen", sbm_pkg::ADDR_STATUS, 8'h03);
         second_low_power_idle <= 1'h0;
         wait_irq(200, hit);
         chk("late", 8'h01, {7'h0, hit});
      end
      second_low_power_idle <= 1'h0;
      rd_chk("istat", sbm_pkg::ADDR_IRQ_STAT, {7'h0, go});
      if (go) begin
         rd_chk("ended", sbm_pkg::ADDR_STATUS, 8'h00);
         rd_chk("rxd", sbm_pkg::ADDR_DATA, ~d);
         chk("far", d, rx);
         wr_reg(sbm_pkg::ADDR_IRQ_MASK, 8'h00);
         repeat (2) @(posedge clk);
         chk("masked", 8'h00, {7'h0, irq});
         wr_reg(sbm_pkg::ADDR_IRQ_MASK, 8'h03);
         wr_reg(sbm_pkg::ADDR_IRQ_STAT, 8'h03);
         rd_chk("clr", sbm_pkg::ADDR_IRQ_STAT, 8'h00);
         chk("irq", 8'h00, {7'h0, irq});
      end
   endtask
   // **********
   // run
   // **********
   initial begin
      clk = 1'h0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         test_done();
      end
   end
   initial begin
      {rstn, wr, rd, second_low_power_idle, load, addr, wdata, tx} = '0;
      {ce, mismatches, compares, cyc} = {1'h1, 96'h0};
      repeat (8) @(posedge clk);
      rstn <= 1'h1;
      t_reset();
      wr_reg(sbm_pkg::ADDR_IRQ_MASK, 8'h03);
      xfer(2'h0, 1'h0, 1'h0, 8'ha5);
      xfer(2'h3, 1'h0, 1'h0, 8'h5a);
      xfer(2'h1, 1'h0, 1'h0, 8'h96);
      xfer(2'h2, 1'h0, 1'h0, 8'h69);
      xfer(2'h1, 1'h1, 1'h1, 8'hc3);
      xfer(2'h2, 1'h1, 1'h1, 8'h3c);
      xfer(2'h2, 1'h0, 1'h1, 8'h81);
      test_done();
   end
endmodule // sbm_top_tb
